// [lgc_phy_model.sv]
`timescale 1ns/100ps
module lgc_phy_model (
   input  wire logic clk_i,  // Link clock
   input  wire logic rstn_i, // Reset, low
   input  wire logic req_i,  // Reset request
   output logic      done_o  // Reset finished
);
   logic [2:0] cnt_reg;
   // Answers late on purpose, drops done once the request goes
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_reg <= 3'h0;
         done_o  <= 1'h0;
      end else begin
         cnt_reg <= req_i ? cnt_reg + 3'h1 : 3'h0;
         done_o  <= req_i && cnt_reg >= 3'h3;
      end
   end
endmodule

// [lgc_phy_reset.sv]
`timescale 1ns/100ps
module lgc_phy_reset
   import lgc_pkg::*;
(
   input  wire logic clk_i,       // Link clock
   input  wire logic rstn_i,      // Power-on reset, active low
   input  wire logic start_i,     // One-cycle start pulse
   input  wire logic done_i,      // Phy side reports reset finished (synchronised)
   output logic      req_o,       // Interface reset request to phy
   output logic      busy_o       // Sequence in progress
);

   typedef struct packed {
      lgc_pr_state_t st;
      logic [1:0]    cnt;
      logic          req;
      logic          busy;
   } lgc_pr_s_t;

   lgc_pr_s_t s_reg;
   lgc_pr_s_t s_next;

   // Request, hold a minimum time, then wait for the phy to finish
   always_comb begin
      s_next = s_reg;
      unique case (s_reg.st)
         LGC_PR_IDLE: begin
            if (start_i) begin
               s_next.st   = LGC_PR_REQ;
               s_next.cnt  = 2'h0;
               s_next.req  = 1'b1;
               s_next.busy = 1'b1;
            end
         end
         LGC_PR_REQ: begin
            s_next.cnt = s_reg.cnt + 2'h1;
            if (s_reg.cnt == 2'(LGC_PHY_RST_MIN_CYC - 1)) begin
               s_next.st = LGC_PR_WAIT;
            end
         end
         LGC_PR_WAIT: begin
            if (done_i) begin
               s_next.st   = LGC_PR_IDLE;
               s_next.req  = 1'b0;
               s_next.busy = 1'b0;
            end
         end
         // Unused code: fall back to idle with the request dropped
         default: begin
            s_next = '{st: LGC_PR_IDLE, cnt: 2'h0, req: 1'b0, busy: 1'b0};
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_reg <= '{st: LGC_PR_IDLE, cnt: 2'h0, req: 1'b0, busy: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign req_o  = s_reg.req;
   assign busy_o = s_reg.busy;

endmodule

// [lgc_pkg.sv]
package lgc_pkg;

   // Bit positions inside the general link control quadlet
   localparam int unsigned LGC_BIT_DATA_INV    = 23;
   localparam int unsigned LGC_BIT_BYTE_ORDER  = 22;
   localparam int unsigned LGC_BIT_TX_RESET    = 21;
   localparam int unsigned LGC_BIT_RX_RESET    = 20;
   localparam int unsigned LGC_BIT_PHY_RESET   = 18;
   localparam int unsigned LGC_BIT_STRICT      = 12;
   localparam int unsigned LGC_BIT_CYC_MASTER  = 11;
   localparam int unsigned LGC_BIT_ROOT        = 5;

   // Reset values of the writable bits
   localparam logic LGC_RST_DATA_INV   = 1'h0;
   localparam logic LGC_RST_TX_RESET   = 1'h0;
   localparam logic LGC_RST_RX_RESET   = 1'h0;
   localparam logic LGC_RST_STRICT     = 1'h0;
   localparam logic LGC_RST_CYC_MASTER = 1'h0;

   // Cycles the phy interface reset request is held before completion is accepted
   localparam int unsigned LGC_PHY_RST_MIN_CYC = 2;

   // Decoded host-port mode
   typedef struct packed {
      logic little_endian;   // Latched byte order
      logic data_invariant;  // Only meaningful when little_endian is set
   } lgc_mode_t;

   // Register write request from the host port
   typedef struct packed {
      logic        wr;
      logic [31:0] data;
   } lgc_wr_t;

   // Phy interface reset sequencer states
   typedef enum logic [1:0] {
      LGC_PR_IDLE,
      LGC_PR_REQ,
      LGC_PR_WAIT
   } lgc_pr_state_t;

endpackage

// [lgc_top.sv]
// How it works
// - Byte-order strap sampled at power reset and held read-only until next power reset.
// - Latched byte order 0 means big-endian host port, 1 means little-endian.
// - Data-invariant setting only takes effect when little-endian is latched.
// - Writing one to transmitter reset synchronously resets the transmitter.
// - Writing one to receiver reset synchronously resets the receiver.
// - Writing one to phy interface reset starts the link-phy interface reset.
// - Phy interface reset bit clears itself when the interface reset completes.
// - Strict filter set discards isochronous packets outside cycle start to subaction gap.
// - Cycle master enabled on root sends cycle start on each cycle-count increment while transmitter reset is clear.
// - A cycle timeout stops cycle master while its enable bit stays set.
// - Data-invariant 0 selects address-invariant mode, 1 selects data-invariant mode.
// - Accesses are whole quadlets; writes to undefined bits are ignored.
// - Read-only root bit follows bus root status, updated after self-identification.
`timescale 1ns/100ps
module lgc_top
   import lgc_pkg::*;
(
   input  wire logic        clk_i,              // Link clock, 200 MHz
   input  wire logic        rstn_i,             // Power-on reset, active low
   input  wire logic        byte_order_strap_i, // Strap pin level
   input  wire logic        reg_wr_i,           // Quadlet write strobe
   input  wire logic [31:0] reg_wdata_i,        // Quadlet write data
   output logic [31:0]      reg_rdata_o,        // Quadlet read data
   input  wire logic        root_i,             // Root status from phy
   input  wire logic        self_id_done_i,     // Self-id phase complete pulse
   input  wire logic        phy_reset_done_i,   // Phy reports interface reset done
   input  wire logic        cycle_timeout_i,    // Cycle timeout event pulse
   input  wire logic        cycle_count_inc_i,  // Cycle-count increment pulse
   input  wire logic        iso_rx_valid_i,     // Isochronous packet arriving
   input  wire logic        iso_window_i,       // Between cycle start and subaction gap
   output logic             iso_rx_accept_o,    // Packet kept by receiver
   output logic             cycle_start_o,      // Send cycle-start packet pulse
   output logic             tx_reset_o,         // Synchronous transmitter reset
   output logic             rx_reset_o,         // Synchronous receiver reset
   output logic             phy_if_reset_o,     // Link-phy interface reset request
   output lgc_mode_t        host_mode_o,        // Host port byte-order mode
   output logic             strict_cycle_filter_o // Current filter setting
);

   // Block state in one struct, apart from the phy reset sequencer state held in u_phy_reset
   typedef struct packed {
      logic [1:0]  strap_sync;
      logic [1:0]  strap_fill;
      logic [1:0]  root_sync;
      logic [1:0]  done_sync;
      logic        strap_taken;
      logic        byte_order;
      logic        data_inv;
      logic        tx_reset;
      logic        rx_reset;
      logic        strict;
      logic        cyc_master;
      logic        cyc_halted;
      logic        root;
      logic        iso_accept;
      logic        cyc_start;
      lgc_mode_t   mode;
      logic [31:0] rdata;
   } lgc_s_t;

   lgc_s_t s_reg;
   lgc_s_t s_next;
   logic   pr_start;
   logic   pr_req;
   logic   pr_busy;

   // Phy interface reset bit is set by a write and ends when the sequencer idles
   assign pr_start = reg_wr_i && reg_wdata_i[LGC_BIT_PHY_RESET] && !pr_busy;

   lgc_phy_reset u_phy_reset (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .start_i (pr_start),
      .done_i  (s_reg.done_sync[1]),
      .req_o   (pr_req),
      .busy_o  (pr_busy)
   );

   // Next-state logic
   always_comb begin
      s_next = s_reg;
      // Pin and phy inputs come from outside: two flops before use
      s_next.strap_sync = {s_reg.strap_sync[0], byte_order_strap_i};
      // Marks when the strap synchroniser holds a real pin sample rather than its reset zero
      s_next.strap_fill = {s_reg.strap_fill[0], 1'b1};
      s_next.root_sync  = {s_reg.root_sync[0], root_i};
      s_next.done_sync  = {s_reg.done_sync[0], phy_reset_done_i};

      // Catch the strap once, just after power reset release; only a power reset repeats it
      if (!s_reg.strap_taken && s_reg.strap_fill[1]) begin
         s_next.byte_order  = s_reg.strap_sync[1];
         s_next.strap_taken = 1'b1;
      end

      // Root bit tracks the phy only at the end of self identification
      if (self_id_done_i) begin
         s_next.root = s_reg.root_sync[1];
      end

      // Whole-quadlet writes; read-only and undefined bits are dropped
      if (reg_wr_i) begin
         s_next.data_inv   = reg_wdata_i[LGC_BIT_DATA_INV];
         s_next.tx_reset   = reg_wdata_i[LGC_BIT_TX_RESET];
         s_next.rx_reset   = reg_wdata_i[LGC_BIT_RX_RESET];
         s_next.strict     = reg_wdata_i[LGC_BIT_STRICT];
         s_next.cyc_master = reg_wdata_i[LGC_BIT_CYC_MASTER];
         // Clearing the enable re-arms the master after a timeout
         if (!reg_wdata_i[LGC_BIT_CYC_MASTER]) begin
            s_next.cyc_halted = 1'b0;
         end
      end
      // A same-cycle clear wins over a timeout; the timeout only halts an enable that stays set
      if (cycle_timeout_i && s_next.cyc_master) begin
         s_next.cyc_halted = 1'b1;
      end

      // Cycle start only from a live master on the root node
      s_next.cyc_start = cycle_count_inc_i && s_reg.cyc_master && !s_reg.cyc_halted
                         && s_reg.root && !s_reg.tx_reset;

      // Strict filter rejects out-of-window packets; receiver in reset keeps nothing
      s_next.iso_accept = iso_rx_valid_i && !s_reg.rx_reset
                          && (iso_window_i || !s_reg.strict);

      // Data-invariant only counts in little-endian mode
      s_next.mode.little_endian  = s_reg.byte_order;
      s_next.mode.data_invariant = s_reg.byte_order && s_reg.data_inv;

      // Read image; phy reset bit shows the running sequence and clears itself
      s_next.rdata = 32'h0;
      s_next.rdata[LGC_BIT_DATA_INV]   = s_next.data_inv;
      s_next.rdata[LGC_BIT_BYTE_ORDER] = s_next.byte_order;
      s_next.rdata[LGC_BIT_TX_RESET]   = s_next.tx_reset;
      s_next.rdata[LGC_BIT_RX_RESET]   = s_next.rx_reset;
      s_next.rdata[LGC_BIT_PHY_RESET]  = pr_busy || pr_start;
      s_next.rdata[LGC_BIT_STRICT]     = s_next.strict;
      s_next.rdata[LGC_BIT_CYC_MASTER] = s_next.cyc_master;
      s_next.rdata[LGC_BIT_ROOT]       = s_next.root;
   end

   // State register
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_reg <= '{strap_sync: 2'h0, strap_fill: 2'h0, root_sync: 2'h0, done_sync: 2'h0,
                    strap_taken: 1'b0, byte_order: 1'b0,
                    data_inv: LGC_RST_DATA_INV, tx_reset: LGC_RST_TX_RESET,
                    rx_reset: LGC_RST_RX_RESET, strict: LGC_RST_STRICT,
                    cyc_master: LGC_RST_CYC_MASTER, cyc_halted: 1'b0, root: 1'b0,
                    iso_accept: 1'b0, cyc_start: 1'b0,
                    mode: '{little_endian: 1'b0, data_invariant: 1'b0},
                    rdata: 32'h0};
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from flops
   assign reg_rdata_o           = s_reg.rdata;
   assign iso_rx_accept_o       = s_reg.iso_accept;
   assign cycle_start_o         = s_reg.cyc_start;
   assign tx_reset_o            = s_reg.tx_reset;
   assign rx_reset_o            = s_reg.rx_reset;
   assign phy_if_reset_o        = pr_req;
   assign host_mode_o           = s_reg.mode;
   assign strict_cycle_filter_o = s_reg.strict;

endmodule

// [lgc_top_asserts.sv]
`timescale 1ns/100ps
module lgc_top_asserts
   import lgc_pkg::*;
(
   input wire logic        clk_i,                // Clock
   input wire logic        rstn_i,               // Reset
   input wire logic        reg_wr_i,             // Write
   input wire logic [31:0] reg_wdata_i,          // Data in
   input wire logic [31:0] reg_rdata_o,          // Image
   input wire logic        cycle_timeout_i,      // Timeout
   input wire logic        cycle_count_inc_i,    // Count step
   input wire logic        iso_rx_valid_i,       // Iso valid
   input wire logic        iso_window_i,         // Iso window
   input wire logic        iso_rx_accept_o,      // Iso kept
   input wire logic        cycle_start_o,        // Start
   input wire logic        tx_reset_o,           // Tx reset
   input wire logic        rx_reset_o,           // Rx reset
   input wire logic        phy_if_reset_o,       // Phy request
   input wire lgc_mode_t   host_mode_o,          // Mode
   input wire logic        strict_cycle_filter_o // Filter
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // Request from idle must then stand at least two cycles
   sequence s_req; reg_wr_i && reg_wdata_i[18] && !reg_rdata_o[18] && !phy_if_reset_o; endsequence
   sequence s_hold; phy_if_reset_o [*2]; endsequence
   property p_phy; s_req |=> s_hold; endproperty
   a_phy: assert property (p_phy) else $error("phy request");
   property p_txrx; tx_reset_o == reg_rdata_o[21] && rx_reset_o == reg_rdata_o[20]; endproperty
   a_txrx: assert property (p_txrx) else $error("link resets");
   property p_wr; reg_wr_i |=> reg_rdata_o[21:20] == $past(reg_wdata_i[21:20]); endproperty
   a_wr: assert property (p_wr) else $error("reset bits");
   property p_fl; reg_wr_i |=> strict_cycle_filter_o == $past(reg_wdata_i[12]); endproperty
   a_fl: assert property (p_fl) else $error("filter bit");
   property p_acc; iso_rx_valid_i && !rx_reset_o && (iso_window_i || !strict_cycle_filter_o) |=> iso_rx_accept_o;
   endproperty
   a_acc: assert property (p_acc) else $error("iso accept");
   property p_rej; iso_rx_valid_i && !iso_window_i && strict_cycle_filter_o |=> !iso_rx_accept_o; endproperty
   a_rej: assert property (p_rej) else $error("iso reject");
   property p_cs; cycle_start_o |-> $past(cycle_count_inc_i) && $past(reg_rdata_o[11]) && $past(reg_rdata_o[5]);
   endproperty
   a_cs: assert property (p_cs) else $error("cycle start");
   property p_to; cycle_timeout_i |-> ##2 !cycle_start_o; endproperty
   a_to: assert property (p_to) else $error("timeout");
   property p_di; !host_mode_o.little_endian |-> !host_mode_o.data_invariant; endproperty
   a_di: assert property (p_di) else $error("invariant");
endmodule
bind lgc_top lgc_top_asserts chk (.clk_i, .rstn_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .cycle_timeout_i,
   .cycle_count_inc_i, .iso_rx_valid_i, .iso_window_i, .iso_rx_accept_o, .cycle_start_o, .tx_reset_o,
   .rx_reset_o, .phy_if_reset_o, .host_mode_o, .strict_cycle_filter_o);

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
   logic        clk_i, rstn_i, byte_order_strap_i, reg_wr_i, root_i, self_id_done_i, phy_reset_done_i;
   logic        cycle_timeout_i, cycle_count_inc_i, iso_rx_valid_i, iso_window_i, iso_rx_accept_o;
   logic        cycle_start_o, tx_reset_o, rx_reset_o, phy_if_reset_o, strict_cycle_filter_o;
   logic [1:0]  mode;
   logic [31:0] reg_wdata_i, reg_rdata_o;
   int          fail_count = 0, checked = 0, n;
   // Design and the phy model answering its interface reset
   lgc_top dut (.clk_i, .rstn_i, .byte_order_strap_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .root_i,
      .self_id_done_i, .phy_reset_done_i, .cycle_timeout_i, .cycle_count_inc_i, .iso_rx_valid_i,
      .iso_window_i, .iso_rx_accept_o, .cycle_start_o, .tx_reset_o, .rx_reset_o, .phy_if_reset_o,
      .host_mode_o(mode), .strict_cycle_filter_o);
   lgc_phy_model phy (.clk_i, .rstn_i, .req_i(phy_if_reset_o), .done_o(phy_reset_done_i));
   initial begin
      clk_i = 1'h0;
      forever #2.5 clk_i = ~clk_i;
   end
   // Inputs move 1 ns after the edge so no race with the design
   task automatic step(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (exp !== got) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Whole quadlet, then an idle cycle so strobes never merge
   task automatic write_reg(input logic [31:0] d);
      reg_wr_i = 1'h1;
      reg_wdata_i = d;
      step(1);
      reg_wr_i = 1'h0;
      step(1);
   endtask
   task automatic pulse(ref logic s);
      s = 1'h1;
      step(1);
      s = 1'h0;
   endtask
   task automatic power_reset(input logic strap);
      byte_order_strap_i = strap;
      rstn_i = 1'h0;
      step(3);
      rstn_i = 1'h1;
      step(5);
   endtask
   task automatic complete_run;
      $display("Checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      {reg_wr_i, root_i, self_id_done_i, cycle_timeout_i, cycle_count_inc_i, iso_rx_valid_i, iso_window_i} = 7'h0;
      reg_wdata_i = 32'h0;
      power_reset(1'h0);
      chk("reset image", 32'h0, reg_rdata_o & 32'h00f41820);
      write_reg(32'h0fc00000);
      chk("quadlet image", 32'h00800000, reg_rdata_o);
      chk("big endian", 3'h0, {reg_rdata_o[22], mode});
      $display("Test endian done");
      iso_rx_valid_i = 1'h1;
      write_reg(32'h00300000);
      chk("resets on", 3'h6, {tx_reset_o, rx_reset_o, iso_rx_accept_o});
      write_reg(32'h0);
      chk("resets off", 3'h1, {tx_reset_o, rx_reset_o, iso_rx_accept_o});
      for (int i = 0; i < 4; i++) begin
         write_reg({19'h0, i[1], 12'h0});
         iso_window_i = i[0];
         step(1);
         chk("iso accept", 32'(i[0] | !i[1]), iso_rx_accept_o);
         chk("filter bit", 32'(i[1]), strict_cycle_filter_o);
      end
      iso_rx_valid_i = 1'h0;
      $display("Test receive done");
      root_i = 1'h1;
      step(3);
      pulse(self_id_done_i);
      step(1);
      chk("root", 1'h1, reg_rdata_o[5]);
      write_reg(32'h00000800);
      pulse(cycle_count_inc_i);
      chk("cycle start", 1'h1, cycle_start_o);
      pulse(cycle_timeout_i);
      pulse(cycle_count_inc_i);
      chk("halted", 2'h2, {reg_rdata_o[11], cycle_start_o});
      write_reg(32'h00000800);
      pulse(cycle_count_inc_i);
      chk("still halted", 1'h0, cycle_start_o);
      write_reg(32'h0);
      write_reg(32'h00000800);
      pulse(cycle_count_inc_i);
      chk("restarted", 1'h1, cycle_start_o);
      root_i = 1'h0;
      step(3);
      pulse(self_id_done_i);
      step(1);
      pulse(cycle_count_inc_i);
      chk("not root", 2'h0, {reg_rdata_o[5], cycle_start_o});
      $display("Test master done");
      write_reg(32'h00040000);
      chk("phy request", 1'h1, phy_if_reset_o);
      write_reg(32'h00040000);
      for (n = 0; n < 20 && reg_rdata_o[18] !== 1'h0; n++) step(1);
      step(3);
      chk("phy clear", 2'h0, {reg_rdata_o[18], phy_if_reset_o});
      if (n == 20) chk("phy clear wait", 32'h0, 32'h1);
      $display("Test phy done");
      power_reset(1'h1);
      byte_order_strap_i = 1'h0;
      write_reg(32'h00800000);
      chk("little endian", 3'h7, {reg_rdata_o[22], mode});
      write_reg(32'h0);
      chk("address invariant", 3'h6, {reg_rdata_o[22], mode});
      $display("Test strap done");
      complete_run();
   end
endmodule
